// ==== hdl/pin_sync_edge.sv ====
// Two-stage pin synchroniser with falling-edge detection
`timescale 1ns/1ps
module pin_sync_edge
  import timer_unit_pkg::*;
#(
  parameter int WIDTH = PIN_TOTAL
)
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Pins and results
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] prev_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_pin
      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          meta_reg[i] <= 1'b0;
          sync_reg[i] <= 1'b0;
          prev_reg[i] <= 1'b0;
        end
        else if (ce)
        begin
          meta_reg[i] <= pins_in[i];
          sync_reg[i] <= meta_reg[i];
          prev_reg[i] <= sync_reg[i];
        end
      end
      assign level[i] = sync_reg[i];
      // Edge taken from the second stage and its delayed copy in prev_reg, never from the first
      assign fall[i] = prev_reg[i] & ~sync_reg[i];
    end
  endgenerate

endmodule : pin_sync_edge

// ==== hdl/three_timer_counter_unit.sv ====
// Three timer/counters with their special function register slave
`timescale 1ns/1ps
module three_timer_counter_unit
  import timer_unit_pkg::*;
(
  // Clock, reset and enable
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  // Special function register bus
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  // External pins
  input wire logic EXT_IRQ_A_PIN,
  input wire logic EXT_IRQ_B_PIN,
  input wire logic TIMER_A_COUNT_PIN,
  input wire logic TIMER_B_COUNT_PIN,
  input wire logic TIMER_C_COUNT_PIN,
  input wire logic TIMER_C_TRIGGER_PIN,
  // Flags and overflow pulses
  output logic TIMER_A_OVERFLOW_FLAG,
  output logic TIMER_B_OVERFLOW_FLAG,
  output logic TIMER_C_OVERFLOW_FLAG,
  output logic TIMER_C_EXTERNAL_FLAG,
  output logic TIMER_B_OVERFLOW_PULSE,
  output logic TIMER_C_OVERFLOW_PULSE
);

  ab_control_t ab_ctrl_reg;
  ab_mode_t ab_mode_reg;
  c_control_t c_ctrl_reg;
  logic [7:0] a_low_reg, a_high_reg, b_low_reg, b_high_reg;
  logic [7:0] c_low_reg, c_high_reg, c_rc_low_reg, c_rc_high_reg;
  logic [7:0] rdata_reg;
  logic b_pulse_reg, c_pulse_reg;
  logic [PIN_TOTAL-1:0] pin_level, pin_fall;

  pin_sync_edge #(.WIDTH(PIN_TOTAL)) u_pins (
    .clk(CLK),
    .reset(RESET),
    .ce(CE),
    .pins_in({TIMER_C_TRIGGER_PIN, TIMER_C_COUNT_PIN, TIMER_B_COUNT_PIN,
              TIMER_A_COUNT_PIN, EXT_IRQ_B_PIN, EXT_IRQ_A_PIN}),
    .level(pin_level),
    .fall(pin_fall)
  );

  logic wr;
  assign wr = CE & SFR_WR;
  logic wr_a, wr_b, wr_c;
  assign wr_a = wr & ((SFR_ADDR == ADDR_A_COUNT_LOW) | (SFR_ADDR == ADDR_A_COUNT_HIGH));
  assign wr_b = wr & ((SFR_ADDR == ADDR_B_COUNT_LOW) | (SFR_ADDR == ADDR_B_COUNT_HIGH));
  assign wr_c = wr & ((SFR_ADDR == ADDR_C_COUNT_LOW) | (SFR_ADDR == ADDR_C_COUNT_HIGH) |
                      (SFR_ADDR == ADDR_C_RELOAD_LOW) | (SFR_ADDR == ADDR_C_RELOAD_HIGH) |
                      (SFR_ADDR == ADDR_C_CONTROL));

  // One count step for modes 0 to 3; the split high byte and the timer B freeze are handled per timer
  function automatic count_step_t count_step(input ab_mode_sel_t mode, input logic [7:0] low,
                                             input logic [7:0] high, input logic tick);
    count_step_t s;
    s.ovf = 1'b0;
    s.low = low;
    s.high = high;
    if (tick)
    begin
      case (mode)
        MODE_13BIT:
        begin
          s.low[4:0] = low[4:0] + LOW5_ONE;
          if (low[4:0] == LOW5_ONES)
          begin
            s.high = high + BYTE_ONE;
            s.ovf = (high == BYTE_ONES);
          end
        end
        MODE_16BIT:
        begin
          {s.high, s.low} = {high, low} + WORD_ONE;
          s.ovf = ({high, low} == WORD_ONES);
        end
        MODE_8BIT_RELOAD:
        begin
          if (low == BYTE_ONES)
          begin
            s.low = high;
            s.ovf = 1'b1;
          end
          else
          begin
            s.low = low + BYTE_ONE;
          end
        end
        default:
        begin
          s.low = low + BYTE_ONE;
          s.ovf = (low == BYTE_ONES);
        end
      endcase
    end
    return s;
  endfunction : count_step

  // Timer A
  logic a_split, a_enable, a_tick;
  count_step_t a_step;
  logic a_ovf, a_high_ovf;
  logic [7:0] a_high_next;

  assign a_split = (ab_mode_reg.a.mode == MODE_SPLIT);
  assign a_enable = ab_ctrl_reg.a_run & (~ab_mode_reg.a.pin_gating | pin_level[PIN_IRQ_A]);
  assign a_tick = a_enable & (ab_mode_reg.a.counter_select ? pin_fall[PIN_A_COUNT] : 1'b1);
  assign a_step = count_step(ab_mode_reg.a.mode, a_low_reg, a_high_reg, a_tick);
  assign a_ovf = a_step.ovf;

  assign a_high_ovf = a_split & ab_ctrl_reg.b_run & (a_high_reg == BYTE_ONES);
  assign a_high_next = !a_split ? a_step.high :
                       (ab_ctrl_reg.b_run ? a_high_reg + BYTE_ONE : a_high_reg);

  // Timer B
  logic b_enable, b_tick, b_ovf;
  count_step_t b_step;

  assign b_enable = (a_split | ab_ctrl_reg.b_run) &
                    (~ab_mode_reg.b.pin_gating | pin_level[PIN_IRQ_B]);
  assign b_tick = b_enable & (ab_mode_reg.b.mode != MODE_SPLIT) &
                  (ab_mode_reg.b.counter_select ? pin_fall[PIN_B_COUNT] : 1'b1);
  assign b_step = count_step(ab_mode_reg.b.mode, b_low_reg, b_high_reg, b_tick);
  assign b_ovf = b_step.ovf;

  // Timer C
  logic c_baud, c_tick, c_trig, c_ovf, c_capture;
  logic [15:0] c_count, c_reload, c_count_next;

  assign c_count = {c_high_reg, c_low_reg};
  assign c_reload = {c_rc_high_reg, c_rc_low_reg};
  assign c_baud = c_ctrl_reg.serial_rx_clock_select | c_ctrl_reg.serial_tx_clock_select;
  assign c_tick = c_ctrl_reg.run &
                  (c_ctrl_reg.counter_select ? pin_fall[PIN_C_COUNT] : 1'b1);
  assign c_trig = pin_fall[PIN_C_TRIGGER] & c_ctrl_reg.external_enable;
  assign c_capture = c_trig & ~c_baud & c_ctrl_reg.capture_select;

  always_comb
  begin
    c_count_next = c_count;
    c_ovf = 1'b0;
    if (c_tick)
    begin
      if (c_count == WORD_ONES)
      begin
        c_ovf = 1'b1;
        if (c_baud | ~c_ctrl_reg.capture_select)
          c_count_next = c_reload;
        else
          c_count_next = WORD_ZERO;
      end
      else
      begin
        c_count_next = c_count + WORD_ONE;
      end
    end
    if (c_trig & ~c_baud & ~c_ctrl_reg.capture_select)
      c_count_next = c_reload;
  end

  // Data registers: a bus write wins over the count in the same cycle
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      a_low_reg <= BYTE_RESET;
      a_high_reg <= BYTE_RESET;
      b_low_reg <= BYTE_RESET;
      b_high_reg <= BYTE_RESET;
      c_low_reg <= BYTE_RESET;
      c_high_reg <= BYTE_RESET;
      c_rc_low_reg <= BYTE_RESET;
      c_rc_high_reg <= BYTE_RESET;
      b_pulse_reg <= 1'b0;
      c_pulse_reg <= 1'b0;
    end
    else if (CE)
    begin
      a_low_reg <= (wr && SFR_ADDR == ADDR_A_COUNT_LOW) ? SFR_WDATA : a_step.low;
      a_high_reg <= (wr && SFR_ADDR == ADDR_A_COUNT_HIGH) ? SFR_WDATA : a_high_next;
      b_low_reg <= (wr && SFR_ADDR == ADDR_B_COUNT_LOW) ? SFR_WDATA : b_step.low;
      b_high_reg <= (wr && SFR_ADDR == ADDR_B_COUNT_HIGH) ? SFR_WDATA : b_step.high;
      c_low_reg <= (wr && SFR_ADDR == ADDR_C_COUNT_LOW) ? SFR_WDATA : c_count_next[7:0];
      c_high_reg <= (wr && SFR_ADDR == ADDR_C_COUNT_HIGH) ? SFR_WDATA : c_count_next[15:8];
      if (wr && SFR_ADDR == ADDR_C_RELOAD_LOW)
        c_rc_low_reg <= SFR_WDATA;
      else if (c_capture)
        c_rc_low_reg <= c_low_reg;
      if (wr && SFR_ADDR == ADDR_C_RELOAD_HIGH)
        c_rc_high_reg <= SFR_WDATA;
      else if (c_capture)
        c_rc_high_reg <= c_high_reg;
      // Overflow pulses feed a baud generator outside this block
      b_pulse_reg <= b_ovf;
      c_pulse_reg <= c_ovf;
    end
  end

  // Control registers; a hardware set beats a software clear in the same cycle
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      ab_ctrl_reg <= ab_control_t'(BYTE_RESET);
      ab_mode_reg <= ab_mode_t'(BYTE_RESET);
    end
    else if (CE)
    begin
      if (wr && SFR_ADDR == ADDR_AB_CONTROL)
        ab_ctrl_reg <= ab_control_t'(SFR_WDATA);
      if (a_ovf)
        ab_ctrl_reg.a_overflow_flag <= 1'b1;
      if (a_split ? a_high_ovf : b_ovf)
        ab_ctrl_reg.b_overflow_flag <= 1'b1;
      if (wr && SFR_ADDR == ADDR_AB_MODE)
        ab_mode_reg <= ab_mode_t'(SFR_WDATA);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      c_ctrl_reg <= c_control_t'(BYTE_RESET);
    else if (CE)
    begin
      if (wr && SFR_ADDR == ADDR_C_CONTROL)
        c_ctrl_reg <= c_control_t'(SFR_WDATA);
      if (c_ovf && !c_baud)
        c_ctrl_reg.overflow_flag <= 1'b1;
      if (c_trig)
        c_ctrl_reg.external_flag <= 1'b1;
    end
  end

  // Registered read; unmapped addresses read zero
  always_ff @(posedge CLK)
  begin
    if (RESET)
      rdata_reg <= BYTE_RESET;
    else if (CE && SFR_RD)
    begin
      case (SFR_ADDR)
        ADDR_AB_CONTROL: rdata_reg <= ab_ctrl_reg;
        ADDR_AB_MODE: rdata_reg <= ab_mode_reg;
        ADDR_A_COUNT_LOW: rdata_reg <= a_low_reg;
        ADDR_B_COUNT_LOW: rdata_reg <= b_low_reg;
        ADDR_A_COUNT_HIGH: rdata_reg <= a_high_reg;
        ADDR_B_COUNT_HIGH: rdata_reg <= b_high_reg;
        ADDR_C_CONTROL: rdata_reg <= c_ctrl_reg;
        ADDR_C_RELOAD_LOW: rdata_reg <= c_rc_low_reg;
        ADDR_C_RELOAD_HIGH: rdata_reg <= c_rc_high_reg;
        ADDR_C_COUNT_LOW: rdata_reg <= c_low_reg;
        ADDR_C_COUNT_HIGH: rdata_reg <= c_high_reg;
        default: rdata_reg <= BYTE_RESET;
      endcase
    end
  end

  assign SFR_RDATA = rdata_reg;
  assign TIMER_A_OVERFLOW_FLAG = ab_ctrl_reg.a_overflow_flag;
  assign TIMER_B_OVERFLOW_FLAG = ab_ctrl_reg.b_overflow_flag;
  assign TIMER_C_OVERFLOW_FLAG = c_ctrl_reg.overflow_flag;
  assign TIMER_C_EXTERNAL_FLAG = c_ctrl_reg.external_flag;
  assign TIMER_B_OVERFLOW_PULSE = b_pulse_reg;
  assign TIMER_C_OVERFLOW_PULSE = c_pulse_reg;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_a_flag_set: assert property (CE && a_ovf |=> TIMER_A_OVERFLOW_FLAG)
    else $error("timer A overflow did not set its flag");
  a_gate_hold: assert property (CE && !a_enable && !a_split && !wr_a
    |=> $stable(a_low_reg) && $stable(a_high_reg))
    else $error("timer A counted while disabled");
  a_mode0_wrap: assert property (CE && ab_mode_reg.a.mode == MODE_13BIT && a_tick && !wr_a &&
    a_low_reg[4:0] == LOW5_ONES && a_high_reg == BYTE_ONES
    |=> a_high_reg == BYTE_RESET && a_low_reg[4:0] == 5'h00 && TIMER_A_OVERFLOW_FLAG)
    else $error("thirteen bit wrap wrong");
  a_mode1_step: assert property (CE && ab_mode_reg.a.mode == MODE_16BIT && a_enable &&
    !ab_mode_reg.a.counter_select && !wr_a
    |=> {a_high_reg, a_low_reg} == $past({a_high_reg, a_low_reg}) + WORD_ONE)
    else $error("timer A did not advance every clock");
  a_mode2_reload: assert property (CE && ab_mode_reg.a.mode == MODE_8BIT_RELOAD && a_tick &&
    a_low_reg == BYTE_ONES && !wr_a
    |=> a_low_reg == $past(a_high_reg) && $stable(a_high_reg))
    else $error("eight bit reload wrong");
  a_b_freeze: assert property (CE && ab_mode_reg.b.mode == MODE_SPLIT && !wr_b
    |=> $stable(b_low_reg) && $stable(b_high_reg))
    else $error("timer B moved in mode 3");
  a_split_high: assert property (CE && a_split && ab_ctrl_reg.b_run &&
    a_high_reg == BYTE_ONES && !wr_a |=> a_high_reg == BYTE_RESET && TIMER_B_OVERFLOW_FLAG)
    else $error("split high byte overflow wrong");
  a_c_reload: assert property (CE && c_tick && c_count == WORD_ONES && !c_capture &&
    (c_baud || !c_ctrl_reg.capture_select) && !wr_c
    |=> {c_high_reg, c_low_reg} == $past(c_reload))
    else $error("timer C reload wrong");
  a_c_capture: assert property (CE && c_capture && !wr_c
    |=> {c_rc_high_reg, c_rc_low_reg} == $past(c_count) && TIMER_C_EXTERNAL_FLAG)
    else $error("timer C capture wrong");
  a_baud_noflag: assert property (CE && c_baud && !TIMER_C_OVERFLOW_FLAG && !wr_c
    |=> !TIMER_C_OVERFLOW_FLAG)
    else $error("overflow flag set in baud mode");
  a_c_pin_count: assert property (CE && c_ctrl_reg.run && c_ctrl_reg.counter_select &&
    !pin_fall[PIN_C_COUNT] && !c_trig && !wr_c |=> $stable(c_count))
    else $error("timer C counted without a pin edge");

  c_capture_seen: cover property (CE && c_capture);
  c_split_overflow: cover property (CE && a_split && a_high_ovf);
  c_baud_reload: cover property (CE && c_baud && c_ovf);
  c_mode2_reload: cover property (CE && ab_mode_reg.a.mode == MODE_8BIT_RELOAD && a_ovf);

endmodule : three_timer_counter_unit

// ==== hdl/timer_unit_pkg.sv ====
// Register map, field layouts and shared types of the three timer/counter unit
package timer_unit_pkg;

  // Special function register addresses
  localparam logic [7:0] ADDR_AB_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_AB_MODE = 8'h89;
  localparam logic [7:0] ADDR_A_COUNT_LOW = 8'h8A;
  localparam logic [7:0] ADDR_B_COUNT_LOW = 8'h8B;
  localparam logic [7:0] ADDR_A_COUNT_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_B_COUNT_HIGH = 8'h8D;
  localparam logic [7:0] ADDR_C_CONTROL = 8'hC8;
  localparam logic [7:0] ADDR_C_RELOAD_LOW = 8'hCA;
  localparam logic [7:0] ADDR_C_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_C_COUNT_LOW = 8'hCC;
  localparam logic [7:0] ADDR_C_COUNT_HIGH = 8'hCD;

  // Reset values and count constants
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [4:0] LOW5_ONE = 5'h01;
  localparam logic [4:0] LOW5_ONES = 5'h1F;
  localparam logic [15:0] WORD_ONE = 16'h0001;
  localparam logic [15:0] WORD_ONES = 16'hFFFF;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // Synchronised pin indices
  localparam int PIN_IRQ_A = 0;
  localparam int PIN_IRQ_B = 1;
  localparam int PIN_A_COUNT = 2;
  localparam int PIN_B_COUNT = 3;
  localparam int PIN_C_COUNT = 4;
  localparam int PIN_C_TRIGGER = 5;
  localparam int PIN_TOTAL = 6;

  typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_8BIT_RELOAD, MODE_SPLIT} ab_mode_sel_t;

  typedef struct packed {
    logic pin_gating;
    logic counter_select;
    ab_mode_sel_t mode;
  } ab_timer_mode_t;

  // Timer B in the upper nibble, timer A in the lower
  typedef struct packed {
    ab_timer_mode_t b;
    ab_timer_mode_t a;
  } ab_mode_t;

  typedef struct packed {
    logic b_overflow_flag;
    logic b_run;
    logic a_overflow_flag;
    logic a_run;
    logic [3:0] ext_irq_bits;
  } ab_control_t;

  typedef struct packed {
    logic overflow_flag;
    logic external_flag;
    logic serial_rx_clock_select;
    logic serial_tx_clock_select;
    logic external_enable;
    logic run;
    logic counter_select;
    logic capture_select;
  } c_control_t;

  typedef struct packed {
    logic ovf;
    logic [7:0] high;
    logic [7:0] low;
  } count_step_t;

endpackage : timer_unit_pkg

// ==== test/sfr_core_model.sv ====
// Processor core model that drives the special function register bus
`timescale 1ns/1ps
module sfr_core_model
(
  // Clock
  input wire logic clk,
  // Register bus
  output logic [7:0] addr,
  output logic wr,
  output logic rd,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  initial
  begin
    addr = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end

  // Strobe stays up through the taking edge and drops on it
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : put

  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : get
endmodule : sfr_core_model

// ==== test/three_timer_counter_unit_tb_top.sv ====
// Self-checking bench of the three timer/counter unit
`timescale 1ns/1ps
module three_timer_counter_unit_tb_top import timer_unit_pkg::*;;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic irq_a = 1'b0;
  logic irq_b = 1'b0;
  logic cnt_pin = 1'b1;
  logic trig = 1'b1;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr;
  logic rd;
  logic [4:0] flags;
  logic [4:0] seen = 5'h00;
  logic pulse_b;
  logic seen_pb = 1'b0;
  logic ce = 1'b1;
  int fails = 0;
  int check_count = 0;
  int seed = 56248;
  logic [7:0] regs [12] = '{ADDR_AB_CONTROL, ADDR_AB_MODE, ADDR_A_COUNT_LOW, ADDR_B_COUNT_LOW,
    ADDR_A_COUNT_HIGH, ADDR_B_COUNT_HIGH, ADDR_C_CONTROL, ADDR_C_RELOAD_LOW, ADDR_C_RELOAD_HIGH,
    ADDR_C_COUNT_LOW, ADDR_C_COUNT_HIGH, 8'h90};
  logic [7:0] c_modes [4] = '{8'h04, 8'h05, 8'h15, 8'h25};
  logic [7:0] trig_modes [3] = '{8'h08, 8'h09, 8'h18};

  initial forever #2.5 clk = ~clk;

  sfr_core_model core (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata));

  three_timer_counter_unit dut (.CLK(clk), .RESET(reset), .CE(ce), .SFR_ADDR(addr),
    .SFR_WR(wr), .SFR_RD(rd), .SFR_WDATA(wdata), .SFR_RDATA(rdata), .EXT_IRQ_A_PIN(irq_a),
    .EXT_IRQ_B_PIN(irq_b), .TIMER_A_COUNT_PIN(cnt_pin), .TIMER_B_COUNT_PIN(cnt_pin),
    .TIMER_C_COUNT_PIN(cnt_pin), .TIMER_C_TRIGGER_PIN(trig),
    .TIMER_A_OVERFLOW_FLAG(flags[0]), .TIMER_B_OVERFLOW_FLAG(flags[1]),
    .TIMER_C_OVERFLOW_FLAG(flags[2]), .TIMER_C_EXTERNAL_FLAG(flags[3]),
    .TIMER_B_OVERFLOW_PULSE(pulse_b), .TIMER_C_OVERFLOW_PULSE(flags[4]));

  // Sticky record, since a stop write may clear a flag set earlier in the run
  always @(negedge clk) seen <= seen | flags;
  always @(negedge clk) seen_pb <= seen_pb | pulse_b;

  function automatic logic [16:0] ab_model(input int m, input logic [7:0] hi,
    input logic [7:0] lo, input int k);
    logic [16:0] r;
    logic [13:0] v;
    r = {1'b0, hi, lo};
    for (int i = 0; i < k; i++)
    begin
      if (m == 0)
      begin
        v = {1'b0, r[15:8], r[4:0]} + 14'h0001;
        r = {r[16] | v[13], v[12:5], r[7:5], v[4:0]};
      end
      else if (m == 1)
        r = {r[16] | (r[15:0] == 16'hFFFF), r[15:0] + 16'h0001};
      else
        r = (r[7:0] == 8'hFF) ? {1'b1, r[15:8], r[15:8]} : {r[16:8], r[7:0] + 8'h01};
    end
    return r;
  endfunction : ab_model

  function automatic logic [16:0] c_model(input logic cap, input logic [15:0] cnt,
    input logic [15:0] rl, input int k);
    logic [16:0] r;
    r = {1'b0, cnt};
    for (int i = 0; i < k; i++)
      r = (r[15:0] == 16'hFFFF) ? {1'b1, cap ? 16'h0000 : rl} : {r[16], r[15:0] + 16'h0001};
    return r;
  endfunction : c_model

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    core.get(a, d);
    chk(d, exp);
  endtask : rchk

  // Count edges seen while on equal n + 2 for this bus timing
  task automatic run_for(input logic [7:0] a, input logic [7:0] v_on, input logic [7:0] v_off,
    input int n);
    core.put(a, v_on);
    repeat (n) @(posedge clk);
    core.put(a, v_off);
  endtask : run_for

  task automatic stop_test;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  initial
  begin
    #400000;
    fails++;
    stop_test();
  end

  initial
  begin
    int t;
    int n;
    int m;
    int g;
    logic pin;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] rh;
    logic [7:0] rl;
    logic [7:0] ctl;
    logic [16:0] e;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    core.put(8'h90, 8'hFF);
    for (int i = 0; i < 12; i++)
      rchk(regs[i], BYTE_RESET);
    for (int i = 1; i < 11; i++)
    begin
      hi = $random(seed);
      // Keep timer A out of split mode, or timer B would count during the walk
      if (i == 1)
        hi[1:0] = 2'b00;
      if (i != 6)
      begin
        core.put(regs[i], hi);
        rchk(regs[i], hi);
      end
    end
    for (int i = 0; i < 24; i++)
    begin
      t = $random(seed) & 1;
      m = {$random(seed)} % 3;
      g = $random(seed) & 1;
      pin = $random(seed);
      hi = $random(seed);
      lo = $random(seed);
      n = {$random(seed)} % 40;
      if (i < 3)
      begin
        hi = 8'hFF;
        lo = 8'hFE;
        m = i;
        g = 0;
      end
      irq_a <= pin;
      irq_b <= pin;
      core.put(ADDR_AB_MODE, 8'(((g << 3) | m) << (t * 4)));
      core.put(t ? ADDR_B_COUNT_LOW : ADDR_A_COUNT_LOW, lo);
      core.put(t ? ADDR_B_COUNT_HIGH : ADDR_A_COUNT_HIGH, hi);
      core.put(ADDR_AB_CONTROL, 8'h00);
      seen = 5'h00;
      seen_pb = 1'b0;
      run_for(ADDR_AB_CONTROL, t ? 8'h40 : 8'h10, 8'h00, n);
      e = ab_model(m, hi, lo, (g && !pin) ? 0 : n + 2);
      rchk(t ? ADDR_B_COUNT_LOW : ADDR_A_COUNT_LOW, e[7:0]);
      rchk(t ? ADDR_B_COUNT_HIGH : ADDR_A_COUNT_HIGH, e[15:8]);
      chk({7'h00, seen[t]}, {7'h00, e[16]});
      chk({7'h00, seen_pb}, {7'h00, e[16] & (t == 1)});
    end
    core.put(ADDR_AB_MODE, 8'h33);
    core.put(ADDR_A_COUNT_LOW, 8'hF0);
    core.put(ADDR_A_COUNT_HIGH, 8'hF8);
    core.put(ADDR_B_COUNT_LOW, 8'h12);
    core.put(ADDR_B_COUNT_HIGH, 8'h34);
    core.put(ADDR_AB_CONTROL, 8'h00);
    seen = 5'h00;
    run_for(ADDR_AB_CONTROL, 8'h50, 8'h00, 20);
    rchk(ADDR_A_COUNT_LOW, 8'h06);
    rchk(ADDR_A_COUNT_HIGH, 8'h0E);
    rchk(ADDR_B_COUNT_LOW, 8'h12);
    chk({6'h00, seen[1:0]}, 8'h03);
    run_for(ADDR_AB_MODE, 8'h13, 8'h33, 10);
    rchk(ADDR_B_COUNT_LOW, 8'h1E);
    rchk(ADDR_B_COUNT_HIGH, 8'h34);
    for (int i = 0; i < 16; i++)
    begin
      ctl = c_modes[{$random(seed)} % 4];
      rh = $random(seed);
      rl = $random(seed);
      hi = $random(seed);
      lo = $random(seed);
      n = {$random(seed)} % 30;
      if (i < 4)
      begin
        ctl = c_modes[i];
        hi = 8'hFF;
        lo = 8'hF8;
        n = 10;
      end
      core.put(ADDR_C_RELOAD_LOW, rl);
      core.put(ADDR_C_RELOAD_HIGH, rh);
      core.put(ADDR_C_COUNT_LOW, lo);
      core.put(ADDR_C_COUNT_HIGH, hi);
      core.put(ADDR_C_CONTROL, 8'h00);
      seen = 5'h00;
      run_for(ADDR_C_CONTROL, ctl, 8'h00, n);
      e = c_model(ctl == 8'h05, {hi, lo}, {rh, rl}, n + 2);
      rchk(ADDR_C_COUNT_LOW, e[7:0]);
      rchk(ADDR_C_COUNT_HIGH, e[15:8]);
      chk({7'h00, seen[2]}, {7'h00, e[16] & (ctl[5:4] == 2'b00)});
      chk({7'h00, seen[4]}, {7'h00, e[16]});
    end
    for (int i = 0; i < 3; i++)
    begin
      core.put(ADDR_C_RELOAD_LOW, 8'h5A);
      core.put(ADDR_C_RELOAD_HIGH, 8'hA5);
      core.put(ADDR_C_COUNT_LOW, 8'h3C);
      core.put(ADDR_C_COUNT_HIGH, 8'hC3);
      core.put(ADDR_C_CONTROL, trig_modes[i]);
      seen = 5'h00;
      trig <= 1'b0;
      repeat (4) @(posedge clk);
      trig <= 1'b1;
      repeat (6) @(posedge clk);
      rchk(ADDR_C_COUNT_HIGH, (i == 0) ? 8'hA5 : 8'hC3);
      rchk(ADDR_C_RELOAD_LOW, (i == 1) ? 8'h3C : 8'h5A);
      chk({7'h00, seen[3]}, 8'h01);
      core.put(ADDR_C_CONTROL, 8'h00);
    end
    core.put(ADDR_A_COUNT_LOW, 8'h00);
    core.put(ADDR_C_COUNT_LOW, 8'h00);
    core.put(ADDR_B_COUNT_LOW, 8'h00);
    core.put(ADDR_AB_MODE, 8'h55);
    core.put(ADDR_AB_CONTROL, 8'h50);
    core.put(ADDR_C_CONTROL, 8'h06);
    repeat (7)
    begin
      cnt_pin <= 1'b0;
      repeat (3) @(posedge clk);
      cnt_pin <= 1'b1;
      repeat (3) @(posedge clk);
    end
    repeat (6) @(posedge clk);
    rchk(ADDR_A_COUNT_LOW, 8'h07);
    rchk(ADDR_C_COUNT_LOW, 8'h07);
    rchk(ADDR_B_COUNT_LOW, 8'h07);
    core.put(ADDR_AB_CONTROL, 8'h00);
    core.put(ADDR_AB_MODE, 8'h01);
    core.put(ADDR_A_COUNT_LOW, 8'h00);
    core.put(ADDR_A_COUNT_HIGH, 8'h00);
    n = 5 + {$random(seed)} % 20;
    // Only the two enabled edges of the stop write may count
    core.put(ADDR_AB_CONTROL, 8'h10);
    ce <= 1'b0;
    repeat (n) @(posedge clk);
    ce <= 1'b1;
    core.put(ADDR_AB_CONTROL, 8'h00);
    rchk(ADDR_A_COUNT_LOW, 8'h02);
    stop_test();
  end
endmodule : three_timer_counter_unit_tb_top
